/* File: blsb_consts.svh */
// Constants for the byte logic, shift and bit unit
`ifndef BLSB_CONSTS_SVH
`define BLSB_CONSTS_SVH

// Operand and index widths
`define BLSB_DATA_W      8
`define BLSB_IDX_W       3
`define BLSB_FLAGS_W     4
`define BLSB_ADDR_W      16
`define BLSB_OP_W        5

// Condition flag bit positions
`define BLSB_FLAG_C      0
`define BLSB_FLAG_V      1
`define BLSB_FLAG_Z      2
`define BLSB_FLAG_N      3

// Reset values
`define BLSB_BYTE_RST    8'h00
`define BLSB_FLAGS_RST   4'h0
`define BLSB_IDX_RST     3'h0
`define BLSB_ADDR_RST    16'h0000

// Flag masks by operation class
`define BLSB_MASK_LOGIC  4'hE
`define BLSB_MASK_SHIFT  4'hF
`define BLSB_MASK_TEST   4'h4
`define BLSB_MASK_CARRY  4'h1
`define BLSB_MASK_NONE   4'h0

`endif

/* File: blsb_pkg.sv */
// Types shared by the byte logic, shift and bit unit
`include "blsb_consts.svh"

package blsb_pkg;

    // Operation codes issued by the decoder
    typedef enum logic [`BLSB_OP_W-1:0] {
        OP_AND                      = 5'h00,
        OP_OR                       = 5'h01,
        OP_XOR                      = 5'h02,
        OP_NOT                      = 5'h03,
        OP_SHIFT_ARITH_LEFT         = 5'h04,
        OP_SHIFT_ARITH_RIGHT        = 5'h05,
        OP_SHIFT_LOGIC_LEFT         = 5'h06,
        OP_SHIFT_LOGIC_RIGHT        = 5'h07,
        OP_ROTATE_LEFT              = 5'h08,
        OP_ROTATE_RIGHT             = 5'h09,
        OP_ROTATE_CARRY_LEFT        = 5'h0A,
        OP_ROTATE_CARRY_RIGHT       = 5'h0B,
        OP_BIT_FORCE_ONE            = 5'h0C,
        OP_BIT_FORCE_ZERO           = 5'h0D,
        OP_BIT_TOGGLE               = 5'h0E,
        OP_BIT_PROBE_ZERO_FLAG      = 5'h0F,
        OP_CARRY_AND_BIT            = 5'h10,
        OP_CARRY_AND_INVERTED_BIT   = 5'h11,
        OP_CARRY_OR_BIT             = 5'h12,
        OP_CARRY_OR_INVERTED_BIT    = 5'h13,
        OP_CARRY_XOR_BIT            = 5'h14,
        OP_CARRY_XOR_INVERTED_BIT   = 5'h15,
        OP_BIT_TO_CARRY             = 5'h16,
        OP_INVERTED_BIT_TO_CARRY    = 5'h17,
        OP_CARRY_TO_BIT             = 5'h18,
        OP_INVERTED_CARRY_TO_BIT    = 5'h19
    } blsb_op_t;

    // Sequencer states, Gray coded along idle-read-write-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RD   = 2'h1,
        ST_WR   = 2'h3,
        ST_DONE = 2'h2
    } blsb_state_t;

endpackage : blsb_pkg

/* File: blsb_alu_if.sv */
// Operand and result bundle between the sequencer and its datapaths
`timescale 1ns/1ps
`include "blsb_consts.svh"

interface blsb_alu_if;
    import blsb_pkg::*;
    blsb_op_t                 op;
    logic [`BLSB_DATA_W-1:0]  opnd;
    logic                     cin;
    logic [`BLSB_IDX_W-1:0]   idx;
    logic [`BLSB_DATA_W-1:0]  sh_res;
    logic                     sh_c;
    logic [`BLSB_DATA_W-1:0]  bit_res;
    logic                     bit_c;
    logic                     bit_z;

    modport ctrl (output op, opnd, cin, idx, input sh_res, sh_c, bit_res, bit_c, bit_z);
    modport shf  (input op, opnd, cin, output sh_res, sh_c);
    modport bop  (input op, opnd, cin, idx, output bit_res, bit_c, bit_z);
endinterface : blsb_alu_if

/* File: blsb_shifter.sv */
// Byte shift and rotate datapath
`timescale 1ns/1ps

module blsb_shifter
    import blsb_pkg::*;
(
    // Operand and result bundle
    blsb_alu_if.shf alu
);

    // One-place shifts; the bit pushed out lands in carry
    always_comb begin
        alu.sh_res = alu.opnd;
        alu.sh_c   = alu.cin;
        case (alu.op)
            OP_SHIFT_ARITH_LEFT,
            OP_SHIFT_LOGIC_LEFT:   {alu.sh_c, alu.sh_res} = {alu.opnd, 1'b0};
            OP_SHIFT_ARITH_RIGHT: begin
                alu.sh_res = {alu.opnd[7], alu.opnd[7:1]};      // Sign kept
                alu.sh_c   = alu.opnd[0];
            end
            OP_SHIFT_LOGIC_RIGHT: begin
                alu.sh_res = {1'b0, alu.opnd[7:1]};
                alu.sh_c   = alu.opnd[0];
            end
            OP_ROTATE_LEFT: begin
                alu.sh_res = {alu.opnd[6:0], alu.opnd[7]};
                alu.sh_c   = alu.opnd[7];
            end
            OP_ROTATE_RIGHT: begin
                alu.sh_res = {alu.opnd[0], alu.opnd[7:1]};
                alu.sh_c   = alu.opnd[0];
            end
            // Nine-bit rings of byte plus carry
            OP_ROTATE_CARRY_LEFT:  {alu.sh_c, alu.sh_res} = {alu.opnd, alu.cin};
            OP_ROTATE_CARRY_RIGHT: {alu.sh_res, alu.sh_c} = {alu.cin, alu.opnd};
            default: ;
        endcase
    end

endmodule : blsb_shifter

/* File: blsb_bitop.sv */
// Single-bit manipulation datapath
`timescale 1ns/1ps
`include "blsb_consts.svh"

module blsb_bitop
    import blsb_pkg::*;
(
    // Operand and result bundle
    blsb_alu_if.bop alu
);

    logic [`BLSB_DATA_W-1:0] sel_mask;
    logic                    sel_bit;

    // One-hot decode of the bit index
    genvar gi;
    generate
        for (gi = 0; gi < `BLSB_DATA_W; gi++) begin : g_mask
            assign sel_mask[gi] = (alu.idx == `BLSB_IDX_W'(gi));
        end
    endgenerate

    assign sel_bit = |(alu.opnd & sel_mask);

    // Byte and carry results; untouched bits always pass through
    always_comb begin
        alu.bit_res = alu.opnd;
        alu.bit_c   = alu.cin;
        alu.bit_z   = ~sel_bit;
        case (alu.op)
            OP_BIT_FORCE_ONE:          alu.bit_res = alu.opnd | sel_mask;
            OP_BIT_FORCE_ZERO:         alu.bit_res = alu.opnd & ~sel_mask;
            OP_BIT_TOGGLE:             alu.bit_res = alu.opnd ^ sel_mask;
            OP_CARRY_AND_BIT:          alu.bit_c   = alu.cin & sel_bit;
            OP_CARRY_AND_INVERTED_BIT: alu.bit_c   = alu.cin & ~sel_bit;
            OP_CARRY_OR_BIT:           alu.bit_c   = alu.cin | sel_bit;
            OP_CARRY_OR_INVERTED_BIT:  alu.bit_c   = alu.cin | ~sel_bit;
            OP_CARRY_XOR_BIT:          alu.bit_c   = alu.cin ^ sel_bit;
            OP_CARRY_XOR_INVERTED_BIT: alu.bit_c   = alu.cin ^ ~sel_bit; // RULE18
            OP_BIT_TO_CARRY:           alu.bit_c   = sel_bit;
            OP_INVERTED_BIT_TO_CARRY:  alu.bit_c   = ~sel_bit;
            OP_CARRY_TO_BIT:           alu.bit_res = alu.cin ? (alu.opnd | sel_mask)
                                                             : (alu.opnd & ~sel_mask);
            OP_INVERTED_CARRY_TO_BIT:  alu.bit_res = alu.cin ? (alu.opnd & ~sel_mask)
                                                             : (alu.opnd | sel_mask);
            default: ;
        endcase
    end

endmodule : blsb_bitop

/* File: blsb_unit.sv */
// Byte logic, shift and single-bit execution unit with memory read-modify-write
// Function
// [RULE1] AND destination byte with register or immediate, write back to destination.
// [RULE2] OR destination byte with register or immediate, write back to destination.
// [RULE3] XOR destination byte with register or immediate, write back to destination.
// [RULE4] Complement replaces a register byte with its ones' complement.
// [RULE5] Arithmetic shifts left and right, result back to same register.
// [RULE6] Logical shifts left and right, result back to same register.
// [RULE7] Plain rotates left and right without carry, result back to register.
// [RULE8] Rotates through carry form a nine-bit ring, updating byte and carry.
// [RULE9] Force selected bit to one; index from immediate or register low bits.
// [RULE10] Force selected bit to zero; index chosen as for forcing one.
// [RULE11] Toggle selected bit; index from immediate or register low bits.
// [RULE12] Zero flag takes inverse of selected bit; operand unchanged.
// [RULE13] Carry becomes carry AND selected bit.
// [RULE14] Carry becomes carry AND inverted bit; index only immediate.
// [RULE15] Carry becomes carry OR selected bit.
// [RULE16] Carry becomes carry OR inverted bit; index only immediate.
// [RULE17] Carry becomes carry XOR selected bit.
// [RULE18] Carry becomes carry XOR inverted bit; index only immediate.
// [RULE19] Carry takes the selected bit; operand unchanged.
// [RULE20] Carry takes the inverted selected bit; index only immediate.
// [RULE21] Selected bit takes carry; other seven bits unchanged.
// [RULE22] Selected bit takes inverted carry; index only immediate.
// [RULE23] Memory targets use read, modify one bit, write whole byte back.
// [RULE24] Logic, shift, rotate set negative and zero from result, clear overflow.
`timescale 1ns/1ps
`include "blsb_consts.svh"

module blsb_unit
    import blsb_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     rstn_in,
    // Request from the decoder
    input  wire logic                     req_valid_in,
    input  wire blsb_op_t                 op_in,
    input  wire logic [`BLSB_DATA_W-1:0]  dst_data_in,
    input  wire logic [`BLSB_DATA_W-1:0]  src_data_in,
    input  wire logic                     src_is_reg_in,
    input  wire logic [`BLSB_IDX_W-1:0]   imm_idx_in,
    input  wire logic                     idx_from_reg_in,
    input  wire logic                     dst_is_mem_in,
    input  wire logic [`BLSB_ADDR_W-1:0]  mem_addr_in,
    input  wire logic [`BLSB_FLAGS_W-1:0] flags_in,
    output logic                          ready_out,
    output logic                          done_out,
    // Write-back to register file and condition flags
    output logic [`BLSB_DATA_W-1:0]       result_out,
    output logic                          result_we_out,
    output logic [`BLSB_FLAGS_W-1:0]      flags_out,
    output logic [`BLSB_FLAGS_W-1:0]      flags_we_out,
    // Memory byte port
    output logic                          mem_rd_out,
    output logic                          mem_wr_out,
    output logic [`BLSB_ADDR_W-1:0]       mem_addr_out,
    output logic [`BLSB_DATA_W-1:0]       mem_wdata_out,
    input  wire logic [`BLSB_DATA_W-1:0]  mem_rdata_in,
    input  wire logic                     mem_ack_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    blsb_state_t              state_r;
    blsb_op_t                 op_r;
    logic [`BLSB_IDX_W-1:0]   idx_r;
    logic [`BLSB_FLAGS_W-1:0] flags_cap_r;
    logic                     busy;
    logic                     accept;
    logic                     accept_mem;
    logic                     mem_ack_rd;
    logic                     latch;
    logic [`BLSB_IDX_W-1:0]   idx_eff;
    logic [`BLSB_DATA_W-1:0]  src_eff;
    logic [`BLSB_DATA_W-1:0]  res_nxt;
    logic [`BLSB_FLAGS_W-1:0] new_flags;
    logic [`BLSB_FLAGS_W-1:0] mask_nxt;
    logic [`BLSB_FLAGS_W-1:0] base_flags;
    logic                     writes_byte;
    logic                     bit_class;
    logic                     imm_only;

    blsb_alu_if alu ();

    ////////////////////////////////////////////////////////////////////////////
    // Datapath instances

    blsb_shifter u_shifter (
        .alu (alu.shf)
    );

    blsb_bitop u_bitop (
        .alu (alu.bop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request decode

    // Bit operations alone may target memory; others always act on the register
    assign bit_class  = (op_in >= OP_BIT_FORCE_ONE);
    assign busy       = (state_r != ST_IDLE);
    assign accept     = (state_r == ST_IDLE) && req_valid_in;
    assign accept_mem = accept && dst_is_mem_in && bit_class;                   // RULE23
    assign mem_ack_rd = (state_r == ST_RD) && mem_ack_in;
    assign latch      = (accept && !accept_mem) || mem_ack_rd;

    // Inverted carry variants only honour the immediate index
    always_comb begin
        imm_only = 1'b0;
        case (op_in)
            OP_CARRY_AND_INVERTED_BIT, OP_CARRY_OR_INVERTED_BIT,
            OP_CARRY_XOR_INVERTED_BIT, OP_INVERTED_BIT_TO_CARRY,
            OP_INVERTED_CARRY_TO_BIT:  imm_only = 1'b1;                         // RULE14 RULE16
            default: ;
        endcase
    end

    // Register index uses only the low three bits of the source byte
    assign idx_eff = (imm_only || !idx_from_reg_in) ? imm_idx_in               // RULE9 RULE20
                                                    : src_data_in[`BLSB_IDX_W-1:0];
    assign src_eff = src_data_in;  // Decoder muxes the immediate onto this bus

    ////////////////////////////////////////////////////////////////////////////
    // Operand steering: live request while idle, latched context after a read

    assign alu.op     = busy ? op_r : op_in;
    assign alu.opnd   = busy ? mem_rdata_in : dst_data_in;                      // RULE23
    assign alu.idx    = busy ? idx_r : idx_eff;
    assign alu.cin    = busy ? flags_cap_r[`BLSB_FLAG_C] : flags_in[`BLSB_FLAG_C];
    assign base_flags = busy ? flags_cap_r : flags_in;

    ////////////////////////////////////////////////////////////////////////////
    // Result and flag selection

    always_comb begin
        res_nxt     = alu.opnd;
        new_flags   = base_flags;
        mask_nxt    = `BLSB_MASK_NONE;
        writes_byte = 1'b0;
        unique case (alu.op)
            OP_AND, OP_OR, OP_XOR, OP_NOT: begin
                unique case (alu.op)
                    OP_AND:  res_nxt = alu.opnd & src_eff;                      // RULE1
                    OP_OR:   res_nxt = alu.opnd | src_eff;                      // RULE2
                    OP_XOR:  res_nxt = alu.opnd ^ src_eff;                      // RULE3
                    default: res_nxt = ~alu.opnd;                               // RULE4
                endcase
                writes_byte = 1'b1;
                mask_nxt    = `BLSB_MASK_LOGIC;                                 // RULE24
            end
            OP_SHIFT_ARITH_LEFT, OP_SHIFT_ARITH_RIGHT, OP_SHIFT_LOGIC_LEFT,
            OP_SHIFT_LOGIC_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
            OP_ROTATE_CARRY_LEFT, OP_ROTATE_CARRY_RIGHT: begin
                res_nxt                 = alu.sh_res;                           // RULE5 RULE6 RULE7
                new_flags[`BLSB_FLAG_C] = alu.sh_c;                             // RULE8
                writes_byte             = 1'b1;
                mask_nxt                = `BLSB_MASK_SHIFT;                     // RULE24
            end
            OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BIT_TOGGLE,
            OP_CARRY_TO_BIT, OP_INVERTED_CARRY_TO_BIT: begin
                res_nxt     = alu.bit_res;                                      // RULE10 RULE11 RULE21 RULE22
                writes_byte = 1'b1;
            end
            OP_BIT_PROBE_ZERO_FLAG: begin
                new_flags[`BLSB_FLAG_Z] = alu.bit_z;                            // RULE12
                mask_nxt                = `BLSB_MASK_TEST;
            end
            OP_CARRY_AND_BIT, OP_CARRY_AND_INVERTED_BIT, OP_CARRY_OR_BIT,
            OP_CARRY_OR_INVERTED_BIT, OP_CARRY_XOR_BIT, OP_CARRY_XOR_INVERTED_BIT,
            OP_BIT_TO_CARRY, OP_INVERTED_BIT_TO_CARRY: begin
                new_flags[`BLSB_FLAG_C] = alu.bit_c;                            // RULE13 RULE15 RULE17 RULE19
                mask_nxt                = `BLSB_MASK_CARRY;
            end
            default: ;  // Undefined codes leave everything alone
        endcase
        // Negative and zero follow the byte; overflow always cleared
        if (mask_nxt[`BLSB_FLAG_N]) begin
            new_flags[`BLSB_FLAG_N] = res_nxt[`BLSB_DATA_W-1];                  // RULE24
            new_flags[`BLSB_FLAG_Z] = (res_nxt == `BLSB_BYTE_RST);
            new_flags[`BLSB_FLAG_V] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: register ops finish in one step, memory ops read, then write only if they modify the byte

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (req_valid_in) state_r <= accept_mem ? ST_RD : ST_DONE;
                ST_RD:   if (mem_ack_in) state_r <= writes_byte ? ST_WR : ST_DONE;  // RULE23
                ST_WR:   if (mem_ack_in) state_r <= ST_DONE;
                ST_DONE: state_r <= ST_IDLE;
            endcase
        end
    end

    // Context held across the memory access; flags are snapshotted because
    // the decoder may not hold them steady while we wait on memory
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_r         <= OP_AND;
            idx_r        <= `BLSB_IDX_RST;
            flags_cap_r  <= `BLSB_FLAGS_RST;
            mem_addr_out <= `BLSB_ADDR_RST;
        end else if (accept) begin
            op_r         <= op_in;
            idx_r        <= idx_eff;
            flags_cap_r  <= flags_in;
            mem_addr_out <= mem_addr_in;
        end
    end

    // Results; the register write enable never fires for memory targets
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            result_out    <= `BLSB_BYTE_RST;
            result_we_out <= 1'b0;
            flags_out     <= `BLSB_FLAGS_RST;
            flags_we_out  <= `BLSB_FLAGS_RST;
        end else if (latch) begin
            result_out    <= res_nxt;
            result_we_out <= writes_byte && !busy;
            flags_out     <= (base_flags & ~mask_nxt) | (new_flags & mask_nxt);
            flags_we_out  <= mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake outputs

    assign ready_out     = (state_r == ST_IDLE);
    assign done_out      = (state_r == ST_DONE);
    assign mem_rd_out    = (state_r == ST_RD);
    assign mem_wr_out    = (state_r == ST_WR);                                  // RULE23
    assign mem_wdata_out = result_out;  // Whole modified byte goes back

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // Snapshot of a register-path request for the checks below
    logic                     chk_reg;
    logic [`BLSB_DATA_W-1:0]  chk_d;
    logic [`BLSB_DATA_W-1:0]  chk_s;
    logic [`BLSB_IDX_W-1:0]   chk_i;
    logic                     chk_c;
    assign chk_reg = accept && !accept_mem;
    always_ff @(posedge sys_clk_in) begin
        chk_d  <= dst_data_in;
        chk_s  <= src_data_in;
        chk_i  <= idx_eff;
        chk_c  <= flags_in[`BLSB_FLAG_C];
    end

    a_and_result: assert property (chk_reg && op_in == OP_AND |=>               // RULE1
        done_out && result_we_out && result_out == (chk_d & chk_s))
        else $error("AND result wrong");
    a_xor_result: assert property (chk_reg && op_in == OP_XOR |=>               // RULE3
        result_out == (chk_d ^ chk_s))
        else $error("XOR result wrong");
    a_not_result: assert property (chk_reg && op_in == OP_NOT |=>               // RULE4
        result_out == ~chk_d)
        else $error("complement result wrong");
    a_shift_arith_right_sign: assert property (chk_reg && op_in == OP_SHIFT_ARITH_RIGHT |=>  // RULE5
        result_out == {chk_d[7], chk_d[7:1]} && flags_out[`BLSB_FLAG_C] == chk_d[0])
        else $error("arithmetic right shift wrong");
    a_rotc_ring: assert property (chk_reg && op_in == OP_ROTATE_CARRY_LEFT |=>  // RULE8
        {flags_out[`BLSB_FLAG_C], result_out} == {chk_d, chk_c})
        else $error("rotate through carry wrong");
    a_probe_zero: assert property (chk_reg && op_in == OP_BIT_PROBE_ZERO_FLAG |=>  // RULE12
        !result_we_out && flags_we_out == `BLSB_MASK_TEST
        && flags_out[`BLSB_FLAG_Z] == !chk_d[chk_i])
        else $error("bit probe zero flag wrong");
    a_force_one: assert property (chk_reg && op_in == OP_BIT_FORCE_ONE |=>      // RULE9
        result_out[chk_i] && (result_out | (8'h01 << chk_i)) == (chk_d | (8'h01 << chk_i)))
        else $error("bit force one wrong");
    a_carry_store: assert property (chk_reg && op_in == OP_CARRY_TO_BIT |=>     // RULE21
        result_out[chk_i] == chk_c && flags_we_out == `BLSB_MASK_NONE)
        else $error("carry to bit wrong");
    a_load_carry: assert property (chk_reg && op_in == OP_BIT_TO_CARRY |=>      // RULE19
        flags_out[`BLSB_FLAG_C] == chk_d[chk_i] && !result_we_out)
        else $error("bit to carry wrong");
    a_logic_ovf: assert property (done_out && flags_we_out[`BLSB_FLAG_N] |->    // RULE24
        !flags_out[`BLSB_FLAG_V] && flags_out[`BLSB_FLAG_Z] == (result_out == 8'h00))
        else $error("logic flags wrong");
    a_rmw_order: assert property (mem_rd_out && mem_ack_in && writes_byte |=>   // RULE23
        mem_wr_out && !mem_rd_out && !result_we_out)
        else $error("memory write not after read");
    a_rmw_wait: assert property (mem_wr_out && !mem_ack_in |=> mem_wr_out       // RULE23
        && $stable(mem_wdata_out))
        else $error("memory write dropped early");

endmodule : blsb_unit

/* File: blsb_mem_model.sv */
// Behavioural memory byte port answering the unit's read and write strobes
`timescale 1ns/1ps

module blsb_mem_model (
    // Clock and strobes from the unit
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    // Wait cycles before each acknowledge
    input  wire logic [3:0]  lat_in,
    // Answer
    output logic [7:0]       rdata_out,
    output logic             ack_out
);
    logic [7:0] mem [256];
    logic [3:0] cnt;

    initial begin
        ack_out   = 1'b0;
        cnt       = 4'h0;
        rdata_out = 8'h00;
    end

    // Read data is only held in the ack cycle; elsewhere it churns so stale use shows
    always @(posedge clk_in) begin
        ack_out   <= 1'b0;
        rdata_out <= ~rdata_out;
        if (!ack_out && (rd_in || wr_in)) begin
            if (cnt == lat_in) begin
                ack_out <= 1'b1;
                cnt     <= 4'h0;
                if (rd_in) rdata_out <= mem[addr_in[7:0]];
                if (wr_in) mem[addr_in[7:0]] <= wdata_in;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : blsb_mem_model

/* File: tb.sv */
// Self-checking bench for the byte logic, shift and bit unit
`timescale 1ns/1ps

module tb;
    import blsb_pkg::*;
    logic        clk, rstn, req, frm, mem, rdy, dn, rwe, rd, wr, ack;
    blsb_op_t    op;
    logic [7:0]  dst, src, res, wd, rdat;
    logic [2:0]  imm;
    logic [3:0]  fin, fout, fwe, lat;
    logic [15:0] ma;
    int          error_cnt = 0;
    int          n_tests = 0;

    blsb_unit blsb_unit_i (.sys_clk_in(clk), .rstn_in(rstn), .req_valid_in(req), .op_in(op),
        .dst_data_in(dst), .src_data_in(src), .src_is_reg_in(frm), .imm_idx_in(imm),
        .idx_from_reg_in(frm), .dst_is_mem_in(mem), .mem_addr_in(16'h0034), .flags_in(fin),
        .ready_out(rdy), .done_out(dn), .result_out(res), .result_we_out(rwe),
        .flags_out(fout), .flags_we_out(fwe), .mem_rd_out(rd), .mem_wr_out(wr),
        .mem_addr_out(ma), .mem_wdata_out(wd), .mem_rdata_in(rdat), .mem_ack_in(ack));
    blsb_mem_model blsb_mem_model_i (.clk_in(clk), .rd_in(rd), .wr_in(wr), .addr_in(ma),
        .wdata_in(wd), .lat_in(lat), .rdata_out(rdat), .ack_out(ack));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end
    endtask : chk8
    task chk4(input logic [3:0] g, input logic [3:0] e);
        n_tests++;
        if (g !== e) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end
    endtask : chk4

    // Reference behaviour; inverted carry ops always use the immediate index
    function automatic void ref_op(input blsb_op_t o, input logic [7:0] d, s,
        input logic [2:0] im, input logic fr, c, output logic [7:0] r, output logic we,
        output logic [3:0] nf, m);
        logic [2:0] i;
        i = (fr && !(o inside {5'h11, 5'h13, 5'h15, 5'h17, 5'h19})) ? s[2:0] : im;
        r = d; we = o < 5'h0F || o > 5'h17; nf = 4'h0; m = 4'h0;
        case (o)
            OP_AND: r = d & s;
            OP_OR: r = d | s;
            OP_XOR: r = d ^ s;
            OP_NOT: r = ~d;
            OP_SHIFT_ARITH_LEFT, OP_SHIFT_LOGIC_LEFT: begin r = d << 1; nf[0] = d[7]; end
            OP_SHIFT_ARITH_RIGHT: begin r = {d[7], d[7:1]}; nf[0] = d[0]; end
            OP_SHIFT_LOGIC_RIGHT: begin r = {1'b0, d[7:1]}; nf[0] = d[0]; end
            OP_ROTATE_LEFT: begin r = {d[6:0], d[7]}; nf[0] = d[7]; end
            OP_ROTATE_RIGHT: begin r = {d[0], d[7:1]}; nf[0] = d[0]; end
            OP_ROTATE_CARRY_LEFT: begin r = {d[6:0], c}; nf[0] = d[7]; end
            OP_ROTATE_CARRY_RIGHT: begin r = {c, d[7:1]}; nf[0] = d[0]; end
            OP_BIT_FORCE_ONE: r[i] = 1'b1;
            OP_BIT_FORCE_ZERO: r[i] = 1'b0;
            OP_BIT_TOGGLE: r[i] = ~d[i];
            OP_BIT_PROBE_ZERO_FLAG: begin nf[2] = ~d[i]; m = 4'h4; end
            OP_CARRY_TO_BIT: r[i] = c;
            OP_INVERTED_CARRY_TO_BIT: r[i] = ~c;
            default: begin
                m = 4'h1;
                case (o)
                    OP_CARRY_AND_BIT: nf[0] = c & d[i];
                    OP_CARRY_AND_INVERTED_BIT: nf[0] = c & ~d[i];
                    OP_CARRY_OR_BIT: nf[0] = c | d[i];
                    OP_CARRY_OR_INVERTED_BIT: nf[0] = c | ~d[i];
                    OP_CARRY_XOR_BIT: nf[0] = c ^ d[i];
                    OP_CARRY_XOR_INVERTED_BIT: nf[0] = c ^ ~d[i];
                    OP_BIT_TO_CARRY: nf[0] = d[i];
                    default: nf[0] = ~d[i];
                endcase
            end
        endcase
        if (o < 5'h0C) begin
            nf[3] = r[7]; nf[2] = (r == 8'h00); m = (o < 5'h04) ? 4'hE : 4'hF;
            if (o < 5'h04) nf[0] = c;
        end
    endfunction : ref_op

    // One request, waited on with a bound, then every result judged
    task run(input blsb_op_t o, input logic [7:0] d, s, input logic [2:0] im,
        input logic fr, input logic [3:0] f, input logic mm);
        logic [7:0] r;
        logic       we;
        logic [3:0] nf, m;
        int         n;
        ref_op(o, d, s, im, fr, f[0], r, we, nf, m);
        @(negedge clk); op = o; dst = d; src = s; imm = im; frm = fr; fin = f; mem = mm;
        req = 1'b1;
        @(negedge clk); req = 1'b0; n = 0;
        while (dn !== 1'b1 && n < 40) begin @(negedge clk); n++; end
        chk4({2'h0, rdy, dn}, 4'h1);
        chk4({3'h0, rwe}, {3'h0, we && !mm});
        if (we && !mm) chk8(res, r);
        chk4(fwe, m);
        chk4(fout, (f & ~m) | (nf & m));
        if (mm) chk8(blsb_mem_model_i.mem[8'h34], r);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    task t_logic;
        for (int k = 0; k < 4; k++) begin
            run(blsb_op_t'(k), 8'hA5, 8'h5A, 3'h0, 1'b0, 4'hF, 1'b0);
            run(blsb_op_t'(k), 8'hA5, 8'h3C, 3'h0, 1'b0, 4'h2, 1'b0);
        end
    endtask : t_logic
    task t_shift;
        for (int k = 4; k < 12; k++) begin
            run(blsb_op_t'(k), 8'h81, 8'h00, 3'h0, 1'b0, 4'h3, 1'b0);
            run(blsb_op_t'(k), 8'h4E, 8'h00, 3'h0, 1'b0, 4'h6, 1'b0);
        end
    endtask : t_shift
    // Bit 2 is one, bit 6 is zero; register index must beat the immediate except on the inverted carry ops
    task t_bits;
        for (int k = 12; k < 26; k++)
            for (int j = 0; j < 4; j++)
                run(blsb_op_t'(k), 8'hA5, 8'hFE, 3'h2, j[0], {3'h5, j[1]}, 1'b0);
    endtask : t_bits
    task t_mem;
        lat = 4'h3;
        blsb_mem_model_i.mem[8'h34] = 8'h5A;
        run(OP_BIT_TOGGLE, 8'h5A, 8'h00, 3'h7, 1'b0, 4'h0, 1'b1);
        run(OP_BIT_PROBE_ZERO_FLAG, 8'hDA, 8'h00, 3'h0, 1'b0, 4'h0, 1'b1);
        lat = 4'h0;
        run(OP_INVERTED_CARRY_TO_BIT, 8'hDA, 8'h00, 3'h1, 1'b1, 4'h1, 1'b1);
    endtask : t_mem

    task wrap_up;
        $display("errors=%0d tests=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0; req = 1'b0; op = OP_AND; dst = 8'h00; src = 8'h00; imm = 3'h0;
        frm = 1'b0; mem = 1'b0; fin = 4'h0; lat = 4'h0;
        repeat (5) @(posedge clk);
        @(negedge clk); rstn = 1'b1;
        t_logic();
        t_shift();
        t_bits();
        t_mem();
        wrap_up();
    end
endmodule : tb
